/* File: include/pcl_regs.svh */
// Timing counts and encodings for the pulse command and limit block
`ifndef PCL_REGS_SVH
`define PCL_REGS_SVH

// Clock period in ns
`define PCL_CLK_PERIOD_NS    8
// Line-driver pulse ceiling in kpps, and the cycles in one shortest half period
`define PCL_LD_RATE_KPPS     500
`define PCL_LD_MIN_HALF_CYC  ((1000000 / (`PCL_LD_RATE_KPPS * 2)) / `PCL_CLK_PERIOD_NS)
// Open-collector pulse ceiling in kpps
`define PCL_OC_RATE_KPPS     200
// Shortest open-collector half period in cycles, rounded up to stay under the ceiling
`define PCL_OC_MIN_HALF_CYC  (((1000000 / (`PCL_OC_RATE_KPPS * 2)) + `PCL_CLK_PERIOD_NS - 1) / `PCL_CLK_PERIOD_NS)
// Pulse input format codes
`define PCL_FMT_QUAD         2'h0
`define PCL_FMT_CWCCW        2'h1
`define PCL_FMT_STEPDIR      2'h2
`define PCL_FMT_ILLEGAL      2'h3
// Overtravel disable default
`define PCL_OT_DISABLE_RST   1'b1
// Brake on limit: zero engages the dynamic brake
`define PCL_BRAKE_ENGAGE     1'b0
// Ratio select quiet time in ms, a host obligation
`define PCL_RATIO_QUIET_MS   10

`endif

/* File: include/pcl_pkg.sv */
// Types shared by the pulse command and limit block
package pcl_pkg;
	typedef enum logic [1:0] {
		PCL_FMT_QUAD_E    = 2'h0,
		PCL_FMT_CWCCW_E   = 2'h1,
		PCL_FMT_STEPDIR_E = 2'h2
	} pcl_fmt_t;

	// Raw pin group, all active as seen after the input circuit
	typedef struct packed {
		logic step_input;
		logic sign_input;
		logic ratio_select_n;
		logic speed_select_low_n;
		logic speed_select_high_n;
		logic cw_limit_n;
		logic ccw_limit_n;
	} pcl_pins_t;

	// Decoded count event
	typedef struct packed {
		logic step;
		logic dir_ccw;
	} pcl_count_t;
endpackage

/* File: rtl/pcl_sync.sv */
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pcl_sync
	import pcl_pkg::*;
(
	input  wire logic      clk,    // System clock
	input  wire logic      resetn, // Async reset, active low
	input  wire pcl_pins_t pins_a, // Asynchronous pins
	output var  pcl_pins_t pins_s  // Synchronised pins
);
	typedef struct packed {
		pcl_pins_t meta;
		pcl_pins_t sync;
	} pcl_sync_st_t;

	pcl_sync_st_t st_q;
	pcl_sync_st_t st_d;

	// First stage feeds only the second stage
	always_comb
	begin
		st_d.meta = pins_a;
		st_d.sync = st_q.meta;
	end

	// Limits reset to open so the axis stays safe until pins settle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st_q <= '{meta: 7'h7F, sync: 7'h7F};
		else
			st_q <= st_d;
	end

	assign pins_s = st_q.sync;
endmodule // pcl_sync
`default_nettype wire

/* File: rtl/pcl_top.sv */
// Command pulse decoder, ratio and speed selection, overtravel limits
// Overview of operation
// - Ratio select tied low chooses the second ratio numerator in position control.
// - Internal velocity mode combines two speed selects into a two-bit code.
// - Open clockwise limit with inhibit enabled blocks clockwise torque.
// - Open counter-clockwise limit with inhibit enabled blocks counter-clockwise torque.
// - Overtravel disable set to one ignores both limits; that is the default.
// - Effective limit engages dynamic brake when brake select is zero, the default.
// - Pulses up to 500kpps line driver or 200kpps open collector are accepted.
// - Three pulse formats: quadrature, separate CW/CCW lines, step with direction.
`timescale 1ns/1ps
`default_nettype none
`include "pcl_regs.svh"
module pcl_top
	import pcl_pkg::*;
(
	input  wire logic       clk,                    // 125 MHz system clock
	input  wire logic       resetn,                 // Async reset, active low
	input  wire logic       step_input,             // Pulse or phase A or CW line
	input  wire logic       sign_input,             // Sign or phase B or CCW line
	input  wire logic       ratio_select_n,         // Low selects second numerator in position control
	input  wire logic       speed_select_low_n,     // Internal speed select bit 0, low active
	input  wire logic       speed_select_high_n,    // Internal speed select bit 1, low active
	input  wire logic       cw_limit_n,             // Low while inside clockwise range
	input  wire logic       ccw_limit_n,            // Low while inside ccw range
	input  wire logic       position_mode,          // High in position control
	input  wire logic       internal_velocity_mode, // High in internal velocity control
	input  wire logic [1:0] pulse_input_format,     // Pulse format select
	input  wire logic       overtravel_disable,     // One ignores both limits
	input  wire logic       brake_on_limit_select,  // Zero brakes on an effective limit
	input  wire logic [15:0] ratio_numerator_first, // First ratio numerator
	input  wire logic [15:0] ratio_numerator_second,// Second ratio numerator
	output logic            count_step,             // One-cycle pulse per command count
	output logic            count_dir_ccw,          // Direction of count_step
	output logic [15:0]     ratio_numerator,        // Numerator in use
	output logic            ratio_second_active,    // Second numerator selected
	output logic [1:0]      speed_code,             // Internal speed code 0..3
	output logic            cw_torque_inhibit,      // No torque in clockwise direction
	output logic            ccw_torque_inhibit,     // No torque in ccw direction
	output logic            dynamic_brake_on        // Dynamic brake request
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	pcl_pins_t pins_a;
	pcl_pins_t pins_s;

	assign pins_a = '{step_input: step_input, sign_input: sign_input,
	                  ratio_select_n: ratio_select_n,
	                  speed_select_low_n: speed_select_low_n,
	                  speed_select_high_n: speed_select_high_n,
	                  cw_limit_n: cw_limit_n, ccw_limit_n: ccw_limit_n};

	// Every pin is synchronised before use
	pcl_sync u_sync (
		.clk    (clk),
		.resetn (resetn),
		.pins_a (pins_a),
		.pins_s (pins_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic        a_prev;
		logic        b_prev;
		pcl_count_t  cnt;
		logic [15:0] numer;
		logic        ratio2;
		logic [1:0]  speed;
		logic        cw_inh;
		logic        ccw_inh;
		logic        brake;
	} pcl_st_t;

	pcl_st_t st_q;
	pcl_st_t st_d;

	logic a_s;
	logic b_s;
	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic b_fall;
	logic lim_cw;
	logic lim_ccw;

	assign a_s    = pins_s.step_input;
	assign b_s    = pins_s.sign_input;
	assign a_rise = a_s & ~st_q.a_prev;
	assign a_fall = ~a_s & st_q.a_prev;
	assign b_rise = b_s & ~st_q.b_prev;
	assign b_fall = ~b_s & st_q.b_prev;
	// Limit counts only when the inhibit is enabled
	assign lim_cw  = pins_s.cw_limit_n & ~overtravel_disable;
	assign lim_ccw = pins_s.ccw_limit_n & ~overtravel_disable;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	// Edge decode is one edge per clock; 125 MHz gives 125 cycles per half period at
	// 500kpps, far above the three-cycle pin latency, so both rates are met
	always_comb
	begin
		st_d        = st_q;
		st_d.a_prev = a_s;
		st_d.b_prev = b_s;
		st_d.cnt    = '0;
		unique case (pulse_input_format)
			`PCL_FMT_QUAD:
			begin
				// Full x4 decode; A leading B counts clockwise
				if (a_rise | a_fall | b_rise | b_fall)
				begin
					st_d.cnt.step    = 1'b1;
					st_d.cnt.dir_ccw = (a_rise | a_fall) ? (a_s == b_s) : (a_s != b_s);
				end
			end
			`PCL_FMT_CWCCW:
			begin
				// Direction from which line pulsed; simultaneous edges cancel
				if (a_rise ^ b_rise)
				begin
					st_d.cnt.step    = 1'b1;
					st_d.cnt.dir_ccw = b_rise;
				end
			end
			`PCL_FMT_STEPDIR:
			begin
				// Sign level sampled at the step edge
				if (a_rise)
				begin
					st_d.cnt.step    = 1'b1;
					st_d.cnt.dir_ccw = b_s;
				end
			end
			default:
				st_d.cnt = '0; // Code 3 is illegal: no counting
		endcase
		// Ratio numerator switch in position control
		st_d.ratio2 = position_mode & ~pins_s.ratio_select_n;
		st_d.numer  = st_d.ratio2 ? ratio_numerator_second : ratio_numerator_first;
		// Speed code; low-active pins give bit set when tied to common
		st_d.speed  = internal_velocity_mode ?
		              {~pins_s.speed_select_high_n, ~pins_s.speed_select_low_n} : 2'h0;
		st_d.cw_inh  = lim_cw;
		st_d.ccw_inh = lim_ccw;
		st_d.brake   = (lim_cw | lim_ccw) & (brake_on_limit_select == `PCL_BRAKE_ENGAGE);
	end

	// State register; edge history resets to the idle-high pin level so that
	// release from reset shows no false edge against the synchroniser's ones
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st_q <= '{a_prev: 1'b1, b_prev: 1'b1, cnt: '0, numer: 16'h0000, ratio2: 1'b0,
			          speed: 2'h0, cw_inh: 1'b0, ccw_inh: 1'b0, brake: 1'b0};
		else
			st_q <= st_d;
	end

	assign count_step          = st_q.cnt.step;
	assign count_dir_ccw       = st_q.cnt.dir_ccw;
	assign ratio_numerator     = st_q.numer;
	assign ratio_second_active = st_q.ratio2;
	assign speed_code          = st_q.speed;
	assign cw_torque_inhibit   = st_q.cw_inh;
	assign ccw_torque_inhibit  = st_q.ccw_inh;
	assign dynamic_brake_on    = st_q.brake;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	a_ratio_second_sel: assert property (@(posedge clk) disable iff (!resetn)
		ratio_second_active |-> ratio_numerator == $past(ratio_numerator_second))
		else $error("Second numerator not applied");
	a_speed_code_map: assert property (@(posedge clk) disable iff (!resetn)
		!$past(internal_velocity_mode) |-> speed_code == 2'h0)
		else $error("Speed code outside internal velocity mode");
	a_cw_limit_act: assert property (@(posedge clk) disable iff (!resetn)
		(pins_s.cw_limit_n && !overtravel_disable) |=> cw_torque_inhibit)
		else $error("Clockwise limit not applied");
	a_ccw_limit_act: assert property (@(posedge clk) disable iff (!resetn)
		(pins_s.ccw_limit_n && !overtravel_disable) |=> ccw_torque_inhibit)
		else $error("Counter-clockwise limit not applied");
	a_limits_ignored: assert property (@(posedge clk) disable iff (!resetn)
		overtravel_disable |=> !cw_torque_inhibit && !ccw_torque_inhibit && !dynamic_brake_on)
		else $error("Limits active while disabled");
	a_brake_on_limit: assert property (@(posedge clk) disable iff (!resetn)
		dynamic_brake_on |-> !$past(brake_on_limit_select) && (cw_torque_inhibit || ccw_torque_inhibit))
		else $error("Brake without effective limit");
	a_step_dir_edge: assert property (@(posedge clk) disable iff (!resetn)
		(pulse_input_format == `PCL_FMT_STEPDIR && a_rise) |=> count_step && count_dir_ccw == $past(b_s))
		else $error("Step/direction count wrong");
	a_step_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
		(pulse_input_format == `PCL_FMT_STEPDIR && count_step) |=> !count_step)
		else $error("Step pulse longer than one cycle");
	a_sync_latency: assert property (@(posedge clk) disable iff (!resetn)
		$rose(step_input) ##1 step_input [*2] |-> ##2 pins_s.step_input)
		else $error("Sync latency wrong");
	// A single-stage synchroniser would show the new level one edge too soon
	a_sync_no_early: assert property (@(posedge clk) disable iff (!resetn)
		$rose(step_input) |=> !pins_s.step_input)
		else $error("Pin seen before two stages");
	a_quad_every_edge: assert property (@(posedge clk) disable iff (!resetn)
		(pulse_input_format == `PCL_FMT_QUAD && ($changed(a_s) || $changed(b_s))) |=> count_step)
		else $error("Quadrature edge not counted");
	a_cwccw_line_dir: assert property (@(posedge clk) disable iff (!resetn)
		(pulse_input_format == `PCL_FMT_CWCCW && (a_rise ^ b_rise)) |=>
		count_step && count_dir_ccw == $past(b_rise))
		else $error("CW/CCW line direction wrong");
	a_illegal_fmt_quiet: assert property (@(posedge clk) disable iff (!resetn)
		pulse_input_format == `PCL_FMT_ILLEGAL |=> !count_step)
		else $error("Count in illegal format");

	c_quad_count:  cover property (@(posedge clk) disable iff (!resetn)
		pulse_input_format == `PCL_FMT_QUAD && count_step);
	c_cwccw_ccw:   cover property (@(posedge clk) disable iff (!resetn)
		pulse_input_format == `PCL_FMT_CWCCW && count_step && count_dir_ccw);
	c_brake:       cover property (@(posedge clk) disable iff (!resetn) dynamic_brake_on);
	c_ratio2:      cover property (@(posedge clk) disable iff (!resetn) ratio_second_active);
	c_stepdir_ccw: cover property (@(posedge clk) disable iff (!resetn)
		pulse_input_format == `PCL_FMT_STEPDIR && count_step && count_dir_ccw);
endmodule // pcl_top
`default_nettype wire

/* File: tb/pcl_host_model.sv */
// Host controller model that drives the command pulse lines
`timescale 1ns/1ps
`default_nettype none
module pcl_host_model
	import pcl_pkg::*;
(
	input  wire logic clk,        // System clock
	output var  logic step_input, // Pulse, phase A or CW line
	output var  logic sign_input  // Sign, phase B or CCW line
);
	////////////////////////////////////////////////////////////
	// Lines idle high so that no edge follows the synchroniser's reset
	initial
	begin
		step_input = 1'b1;
		sign_input = 1'b1;
	end

	// Holds a level for hc cycles; 125 is the half period at the fastest line-driver rate
	task automatic hold(input int hc);
		repeat (hc) @(posedge clk);
		#1;
	endtask

	// One command pulse; quadrature makes four edges, A leading for CW
	task automatic send(input logic [1:0] f, input logic ccw, input int hc);
		if (f == PCL_FMT_QUAD_E)
			repeat (2)
			begin
				if (ccw)
					sign_input = ~sign_input;
				else
					step_input = ~step_input;
				hold(hc);
				if (ccw)
					step_input = ~step_input;
				else
					sign_input = ~sign_input;
				hold(hc);
			end
		else
		begin
			// Sign settles two half periods before the rising step edge
			if (f == PCL_FMT_STEPDIR_E)
				sign_input = ccw;
			hold(hc);
			if (f == PCL_FMT_CWCCW_E && ccw)
				sign_input = 1'b0;
			else
				step_input = 1'b0;
			hold(hc);
			step_input = 1'b1;
			if (f != PCL_FMT_STEPDIR_E)
				sign_input = 1'b1;
			hold(hc);
			sign_input = 1'b1;
			hold(hc);
		end
	endtask
endmodule // pcl_host_model
`default_nettype wire

/* File: tb/pcl_top_bench.sv */
// Self-checking bench for the pulse command and limit block
`timescale 1ns/1ps
`default_nettype none
`include "pcl_regs.svh"
module pcl_top_bench;
	////////////////////////////////////////////////////////////
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	wire         step_input;
	wire         sign_input;
	logic        ratio_select_n = 1'b1;
	logic        speed_select_low_n = 1'b1;
	logic        speed_select_high_n = 1'b1;
	logic        cw_limit_n = 1'b0;
	logic        ccw_limit_n = 1'b0;
	logic        position_mode = 1'b1;
	logic        internal_velocity_mode = 1'b0;
	logic [1:0]  pulse_input_format = 2'h0;
	logic        overtravel_disable = 1'b1;
	logic        brake_on_limit_select = 1'b0;
	logic [15:0] first = 16'h1234;
	logic [15:0] second = 16'habcd;
	logic        count_step, count_dir_ccw, ratio_second_active;
	logic        cw_torque_inhibit, ccw_torque_inhibit, dynamic_brake_on;
	logic [15:0] ratio_numerator;
	logic [1:0]  speed_code;
	logic [15:0] cnt [2];
	logic        exp_cw, exp_ccw;
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles = 0;

	pcl_host_model host (.clk(clk), .step_input(step_input), .sign_input(sign_input));

	pcl_top uut (.clk(clk), .resetn(resetn), .step_input(step_input),
		.sign_input(sign_input), .ratio_select_n(ratio_select_n),
		.speed_select_low_n(speed_select_low_n), .speed_select_high_n(speed_select_high_n),
		.cw_limit_n(cw_limit_n), .ccw_limit_n(ccw_limit_n), .position_mode(position_mode),
		.internal_velocity_mode(internal_velocity_mode),
		.pulse_input_format(pulse_input_format), .overtravel_disable(overtravel_disable),
		.brake_on_limit_select(brake_on_limit_select), .ratio_numerator_first(first),
		.ratio_numerator_second(second), .count_step(count_step),
		.count_dir_ccw(count_dir_ccw), .ratio_numerator(ratio_numerator),
		.ratio_second_active(ratio_second_active), .speed_code(speed_code),
		.cw_torque_inhibit(cw_torque_inhibit), .ccw_torque_inhibit(ccw_torque_inhibit),
		.dynamic_brake_on(dynamic_brake_on));

	// 125 MHz clock
	always #4 clk = ~clk;

	// Tallies counts by direction; an unknown direction lands in the CW tally
	always @(posedge clk)
		if (count_step === 1'b1)
			cnt[count_dir_ccw === 1'b1] <= cnt[count_dir_ccw === 1'b1] + 16'h0001;

	// Hang guard, well above the roughly 14200 cycles the tests need
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			mismatches++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic final_report;
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence: pulses, ratio, speed code, limits
	initial
	begin
		cnt[0] = 16'h0000;
		cnt[1] = 16'h0000;
		cyc(12);
		chk(ratio_numerator, 16'h0000);
		resetn = 1'b1;
		cyc(4);
		// Every format both ways at both rate ceilings; format 3 is refused
		for (int f = 0; f < 4; f++)
			for (int d = 0; d < 2; d++)
			begin
				pulse_input_format = f[1:0];
				cyc(4);
				cnt[0] = 16'h0000;
				cnt[1] = 16'h0000;
				host.send(f[1:0], d[0], `PCL_LD_MIN_HALF_CYC);
				host.send(f[1:0], d[0], `PCL_OC_MIN_HALF_CYC);
				cyc(4);
				chk(cnt[d], (f == 3) ? 16'h0000 : (f == 0) ? 16'h0008 : 16'h0002);
				chk(cnt[1 - d], 16'h0000);
			end
		// No pulses run while ratio select moves
		for (int c = 0; c < 4; c++)
		begin
			position_mode = c[1];
			ratio_select_n = c[0];
			cyc(4);
			chk(ratio_numerator, (c == 2) ? second : first);
			chk(ratio_second_active, c == 2);
		end
		position_mode = 1'b0;
		for (int c = 0; c < 8; c++)
		begin
			internal_velocity_mode = c[2];
			speed_select_low_n = ~c[0];
			speed_select_high_n = ~c[1];
			cyc(4);
			chk(speed_code, c[2] ? c[1:0] : 2'h0);
		end
		// A pin change must not show before two flops have passed
		overtravel_disable = 1'b0;
		cyc(4);
		cw_limit_n = 1'b1;
		cyc(2);
		chk(cw_torque_inhibit, 1'b0);
		for (int c = 0; c < 16; c++)
		begin
			overtravel_disable = c[3];
			brake_on_limit_select = c[2];
			cw_limit_n = c[1];
			ccw_limit_n = c[0];
			cyc(4);
			exp_cw = !c[3] && c[1];
			exp_ccw = !c[3] && c[0];
			chk(cw_torque_inhibit, exp_cw);
			chk(ccw_torque_inhibit, exp_ccw);
			chk(dynamic_brake_on, (exp_cw || exp_ccw) && !c[2]);
		end
		final_report();
	end
endmodule // pcl_top_bench
`default_nettype wire
